// *** rtl/gcc_regs.sv ***
// Gate current configuration register bank: static current selection, initial
// precharge, active charge and freewheel codes, with bank-switched offsets.
// Assumes the access port and bank select come from logic on the same clock.
`timescale 1ns/10ps

module gcc_regs (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      sys_rst,
	// Register access
	input  wire gcc_pkg::gcc_req_t         req,
	input  wire logic                      bank_sel,
	output      logic                      rd_valid_q,
	output      logic [15:0]               rd_data_q,
	// Static current selection fields
	output      logic [7:0]                static_select_q,
	output      logic [3:0]                setting_one_q,
	output      logic [3:0]                setting_two_q,
	output      gcc_pkg::gcc_bridge_codes_t bridge_code_q,
	// PWM channel code banks
	output      gcc_pkg::gcc_codes_t       precharge_q,
	output      gcc_pkg::gcc_codes_t       active_q,
	output      gcc_pkg::gcc_codes_t       freewheel_q
);
	import gcc_pkg::*;

	// ****************************************************************
	// Helpers
	// ****************************************************************
	// True when an access hits the given offset in the given bank
	function automatic logic hit_f(input gcc_req_t r, input logic bank, input logic [4:0] off,
		input logic want);
		hit_f = r.valid && (r.addr == off) && (bank == want);
	endfunction

	// Per-bridge applied code from the select bits and the two settings
	function automatic gcc_bridge_codes_t apply_f(input logic [7:0] sel, input logic [3:0] one,
		input logic [3:0] two);
		gcc_bridge_codes_t res;
		res = '0;
		for (int i = 0; i < 8; i++) begin
			res[i] = sel[i] ? two : one;
		end
		apply_f = res;
	endfunction

	// Read word of a code register, reserved top bit forced low
	function automatic logic [15:0] code_word_f(input gcc_codes_t c);
		code_word_f = {1'b0, c};
	endfunction

	// ****************************************************************
	// Address decode
	// ****************************************************************
	logic hit_static;
	logic hit_pchg;
	logic hit_act;
	logic hit_fw;

	// Bank select steers the two shared offsets
	assign hit_static = hit_f(req, bank_sel, GCC_OFF_STATIC_PCHG, GCC_BANK_ZERO);
	assign hit_pchg   = hit_f(req, bank_sel, GCC_OFF_STATIC_PCHG, GCC_BANK_ONE);
	assign hit_act    = hit_f(req, bank_sel, GCC_OFF_ACT_FW, GCC_BANK_ZERO);
	assign hit_fw     = hit_f(req, bank_sel, GCC_OFF_ACT_FW, GCC_BANK_ONE);

	// ****************************************************************
	// Static current selection register
	// ****************************************************************
	// Only the bank-0 register at 0x0a is written
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			static_select_q <= GCC_RST_STATIC[GCC_SEL_MSB:GCC_SEL_LSB];
			setting_two_q   <= GCC_RST_STATIC[GCC_SET2_MSB:GCC_SET2_LSB];
			setting_one_q   <= GCC_RST_STATIC[GCC_SET1_MSB:GCC_SET1_LSB];
		end else if (hit_static && req.write) begin
			static_select_q <= req.wdata[GCC_SEL_MSB:GCC_SEL_LSB];
			setting_two_q   <= req.wdata[GCC_SET2_MSB:GCC_SET2_LSB];
			setting_one_q   <= req.wdata[GCC_SET1_MSB:GCC_SET1_LSB];
		end
	end

	// Applied code per half-bridge, one cycle behind the register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			bridge_code_q <= '0;
		end else begin
			bridge_code_q <= apply_f(static_select_q, setting_one_q, setting_two_q);
		end
	end

	// ****************************************************************
	// PWM channel code registers
	// ****************************************************************
	gcc_chan_reg u_precharge (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wr_en   (hit_pchg && req.write),
		.wdata   (req.wdata),
		.codes_q (precharge_q)
	);

	gcc_chan_reg u_active (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wr_en   (hit_act && req.write),
		.wdata   (req.wdata),
		.codes_q (active_q)
	);

	gcc_chan_reg u_freewheel (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wr_en   (hit_fw && req.write),
		.wdata   (req.wdata),
		.codes_q (freewheel_q)
	);

	// ****************************************************************
	// Read path
	// ****************************************************************
	logic [15:0] rd_data_d;

	// Selected register word; unmapped offsets read as zero
	always_comb begin
		rd_data_d = '0;
		if (hit_static) begin
			rd_data_d = {static_select_q, setting_two_q, setting_one_q};
		end else if (hit_pchg) begin
			rd_data_d = code_word_f(precharge_q);
		end else if (hit_act) begin
			rd_data_d = code_word_f(active_q);
		end else if (hit_fw) begin
			rd_data_d = code_word_f(freewheel_q);
		end
	end

	// Read answer one cycle after the request
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_valid_q <= 1'b0;
			rd_data_q  <= '0;
		end else begin
			rd_valid_q <= req.valid && !req.write;
			if (req.valid && !req.write) begin
				rd_data_q <= rd_data_d;
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	AST_BANK0_STATIC_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		(req.valid && req.write && req.addr == GCC_OFF_STATIC_PCHG && bank_sel == GCC_BANK_ZERO) |=>
		({static_select_q, setting_two_q, setting_one_q} == $past(req.wdata)))
		else $error("static selection not written in bank 0");

	AST_BANK1_PCHG_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		(req.valid && req.write && req.addr == GCC_OFF_STATIC_PCHG && bank_sel == GCC_BANK_ONE) |=>
		(precharge_q == $past(req.wdata[GCC_CODE_MSB:0])))
		else $error("initial precharge not written in bank 1");

	AST_BANK0_ACT_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		(req.valid && req.write && req.addr == GCC_OFF_ACT_FW && bank_sel == GCC_BANK_ZERO) |=>
		(active_q == $past(req.wdata[GCC_CODE_MSB:0])))
		else $error("active charge not written in bank 0");

	AST_BANK1_FW_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
		(req.valid && req.write && req.addr == GCC_OFF_ACT_FW && bank_sel == GCC_BANK_ONE) |=>
		(freewheel_q == $past(req.wdata[GCC_CODE_MSB:0])))
		else $error("freewheel codes not written in bank 1");

	AST_OTHER_BANK_KEPT: assert property (@(posedge clk) disable iff (sys_rst)
		(req.valid && req.write && (req.addr == GCC_OFF_STATIC_PCHG || req.addr == GCC_OFF_ACT_FW)) |=>
		($past(bank_sel) ? ($stable({static_select_q, setting_two_q, setting_one_q}) && $stable(active_q))
			: ($stable(precharge_q) && $stable(freewheel_q))))
		else $error("write disturbed the other bank");

	AST_RESERVED_READ_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
		(req.valid && !req.write && ((req.addr == GCC_OFF_STATIC_PCHG && bank_sel == GCC_BANK_ONE)
			|| (req.addr == GCC_OFF_ACT_FW && bank_sel == GCC_BANK_ZERO)))
		|=> (rd_valid_q && !rd_data_q[GCC_RSV_BIT]
			&& rd_data_q[GCC_CODE_MSB:0] == ($past(req.addr) == GCC_OFF_STATIC_PCHG ? precharge_q : active_q)))
		else $error("reserved bit or code word wrong on read");

	AST_BRIDGE_APPLY: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(sys_rst) |->
		(bridge_code_q == apply_f($past(static_select_q), $past(setting_one_q), $past(setting_two_q))))
		else $error("bridge applied code does not follow its select bit");

	AST_RESET_VALUES: assert property (@(posedge clk) disable iff (sys_rst)
		$past(sys_rst) |->
		({static_select_q, setting_two_q, setting_one_q} == GCC_RST_STATIC
			&& active_q == GCC_RST_CODES[GCC_CODE_MSB:0] && precharge_q == GCC_RST_CODES[GCC_CODE_MSB:0]
			&& freewheel_q == GCC_RST_CODES[GCC_CODE_MSB:0]))
		else $error("register bank reset value wrong");

	AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (sys_rst)
		(req.valid && !req.write && req.addr != GCC_OFF_STATIC_PCHG && req.addr != GCC_OFF_ACT_FW) |=>
		(rd_valid_q && rd_data_q == 16'h0000) ##1 (!rd_valid_q || $past(req.valid && !req.write)))
		else $error("unmapped read did not answer zero");

	AST_RD_VALID_ONLY_READ: assert property (@(posedge clk) disable iff (sys_rst)
		!$past(sys_rst) |->
		(rd_valid_q == $past(req.valid && !req.write)))
		else $error("read answer strobe does not match a read request");

	AST_STATIC_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		!(req.valid && req.write && req.addr == GCC_OFF_STATIC_PCHG && bank_sel == GCC_BANK_ZERO) |=>
		$stable({static_select_q, setting_two_q, setting_one_q}))
		else $error("static selection changed without its write");

	AST_PCHG_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		!(req.valid && req.write && req.addr == GCC_OFF_STATIC_PCHG && bank_sel == GCC_BANK_ONE) |=>
		$stable(precharge_q))
		else $error("initial precharge changed without its write");

	AST_ACT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		!(req.valid && req.write && req.addr == GCC_OFF_ACT_FW && bank_sel == GCC_BANK_ZERO) |=>
		$stable(active_q))
		else $error("active charge changed without its write");

	AST_FW_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		!(req.valid && req.write && req.addr == GCC_OFF_ACT_FW && bank_sel == GCC_BANK_ONE) |=>
		$stable(freewheel_q))
		else $error("freewheel codes changed without their write");

endmodule

// *** rtl/gcc_pkg.sv ***
// Package for the gate current configuration register bank: offsets, field
// positions, reset values and the carrier types shared by the bank modules.
// Assumes a register access source on the same clock (the serial frame decoder).
package gcc_pkg;

	// ****************************************************************
	// Register offsets and bank values
	// ****************************************************************
	localparam logic [4:0] GCC_OFF_STATIC_PCHG = 5'h0a;
	localparam logic [4:0] GCC_OFF_ACT_FW      = 5'h0b;
	localparam logic       GCC_BANK_ZERO       = 1'b0;
	localparam logic       GCC_BANK_ONE        = 1'b1;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int GCC_SEL_MSB  = 15;
	localparam int GCC_SEL_LSB  = 8;
	localparam int GCC_SET2_MSB = 7;
	localparam int GCC_SET2_LSB = 4;
	localparam int GCC_SET1_MSB = 3;
	localparam int GCC_SET1_LSB = 0;
	localparam int GCC_RSV_BIT  = 15;
	localparam int GCC_CODE_MSB = 14;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [15:0] GCC_RST_STATIC = 16'h0044;
	localparam logic [15:0] GCC_RST_CODES  = 16'h18c6;

	// ****************************************************************
	// Carrier types
	// ****************************************************************
	// One register access from the frame decoder
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [4:0]  addr;
		logic [15:0] wdata;
	} gcc_req_t;

	// Three per-channel 5-bit current codes, channel 3 in the top bits
	typedef struct packed {
		logic [4:0] ch3;
		logic [4:0] ch2;
		logic [4:0] ch1;
	} gcc_codes_t;

	// Applied static code per half-bridge, index 0 is bridge 1
	typedef logic [7:0][3:0] gcc_bridge_codes_t;

endpackage

// *** rtl/gcc_chan_reg.sv ***
// Three-channel 5-bit current code register, used for the initial precharge,
// active charge and freewheel banks. Assumes writes arrive already decoded.
`timescale 1ns/10ps

module gcc_chan_reg (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// Decoded write
	input  wire logic               wr_en,
	input  wire logic [15:0]        wdata,
	// Stored codes
	output      gcc_pkg::gcc_codes_t codes_q
);
	import gcc_pkg::*;

	// ****************************************************************
	// Code storage; bit 15 of the write word is dropped, it has no storage
	// ****************************************************************
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			codes_q <= GCC_RST_CODES[GCC_CODE_MSB:0];
		end else if (wr_en) begin
			codes_q <= wdata[GCC_CODE_MSB:0];
		end
	end

endmodule

// *** tb/gcc_host_model.sv ***
// Host model: issues single register accesses on the strobe port.
// Assumes one clock shared with the register bank.
`timescale 1ns/10ps

module gcc_host_model (
	// Clock
	input  wire logic              clk,
	// Access port
	output      gcc_pkg::gcc_req_t req,
	output      logic              bank_sel,
	input  wire logic              rd_valid_q,
	input  wire logic [15:0]       rd_data_q
);
	import gcc_pkg::*;

	// Idle port at time zero
	initial begin
		req = '0;
		bank_sel = 1'b0;
	end

	// One access held for one edge, then released with scrambled qualifiers
	task automatic access(input logic b, input logic w, input logic [4:0] a, input logic [15:0] d,
		output logic ok, output logic [15:0] q);
		@(posedge clk);
		req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
		bank_sel <= b;
		@(posedge clk);
		req.valid <= 1'b0;
		req.wdata <= ~d;
		bank_sel <= ~b;
		#1;
		ok = (rd_valid_q === ~w);
		q = rd_data_q;
	endtask
endmodule

// *** tb/gcc_regs_tb.sv ***
// Testbench for the gate current register bank, driven through the host model.
// Assumes a 25 MHz clock and the strobe access port of the bank.
`timescale 1ns/10ps

module gcc_regs_tb;
	import gcc_pkg::*;

	// ****************************************************************
	// Signals
	// ****************************************************************
	logic              clk = 1'b0;
	logic              sys_rst = 1'b1;
	gcc_req_t          req;
	logic              bank_sel;
	logic              rd_valid_q;
	logic [15:0]       rd_data_q;
	logic [7:0]        static_select_q;
	logic [3:0]        setting_one_q;
	logic [3:0]        setting_two_q;
	gcc_bridge_codes_t bridge_code_q;
	gcc_codes_t        precharge_q;
	gcc_codes_t        active_q;
	gcc_codes_t        freewheel_q;
	int                miscompares = 0;
	int                n_tests = 0;

	// Clock generator
	always #20 clk = ~clk;

	gcc_host_model u_host (.clk(clk), .req(req), .bank_sel(bank_sel), .rd_valid_q(rd_valid_q),
		.rd_data_q(rd_data_q));

	gcc_regs u_dut (.clk(clk), .sys_rst(sys_rst), .req(req), .bank_sel(bank_sel), .rd_valid_q(rd_valid_q),
		.rd_data_q(rd_data_q), .static_select_q(static_select_q), .setting_one_q(setting_one_q),
		.setting_two_q(setting_two_q), .bridge_code_q(bridge_code_q), .precharge_q(precharge_q),
		.active_q(active_q), .freewheel_q(freewheel_q));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rd(input logic b, input logic [4:0] a, input logic [15:0] exp);
		logic        ok;
		logic [15:0] q;
		u_host.access(b, 1'b0, a, 16'h0000, ok, q);
		check({31'h0, ok}, 32'h1);
		check({16'h0, q}, {16'h0, exp});
	endtask

	task automatic wr(input logic b, input logic [4:0] a, input logic [15:0] d);
		logic        ok;
		logic [15:0] q;
		u_host.access(b, 1'b1, a, d, ok, q);
		check({31'h0, ok}, 32'h1);
	endtask

	// Applied code per bridge from a selection word
	function automatic logic [31:0] bridges(input logic [15:0] r);
		for (int i = 0; i < 8; i++) begin
			bridges[i*4 +: 4] = r[8+i] ? r[7:4] : r[3:0];
		end
	endfunction

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic test_reset();
		rd(1'b0, 5'h0a, 16'h0044);
		rd(1'b1, 5'h0a, 16'h18c6);
		rd(1'b0, 5'h0b, 16'h18c6);
		rd(1'b1, 5'h0b, 16'h18c6);
		check({16'h0000, static_select_q, setting_two_q, setting_one_q}, 32'h0044);
		check(bridge_code_q, 32'h4444_4444);
		$display("test reset done");
	endtask

	task automatic test_static();
		wr(1'b0, 5'h0a, 16'ha53c);
		@(posedge clk);
		#1;
		check({16'h0000, static_select_q, setting_two_q, setting_one_q}, 32'ha53c);
		check(bridge_code_q, bridges(16'ha53c));
		rd(1'b0, 5'h0a, 16'ha53c);
		rd(1'b1, 5'h0a, 16'h18c6);
		$display("test static done");
	endtask

	task automatic test_codes();
		wr(1'b1, 5'h0a, 16'hffff);
		rd(1'b1, 5'h0a, 16'h7fff);
		check({17'h0_0000, precharge_q}, 32'h7fff);
		rd(1'b0, 5'h0a, 16'ha53c);
		wr(1'b0, 5'h0b, 16'habcd);
		rd(1'b0, 5'h0b, 16'h2bcd);
		check({17'h0_0000, active_q}, 32'h2bcd);
		wr(1'b1, 5'h0b, 16'h1234);
		rd(1'b1, 5'h0b, 16'h1234);
		check({17'h0_0000, freewheel_q}, 32'h1234);
		rd(1'b0, 5'h0b, 16'h2bcd);
		rd(1'b0, 5'h0c, 16'h0000);
		$display("test codes done");
	endtask

	// Reset again in mid-run, while every register holds a written value
	task automatic test_rerun();
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(1'b0, 5'h0a, 16'h0044);
		rd(1'b1, 5'h0a, 16'h18c6);
		rd(1'b0, 5'h0b, 16'h18c6);
		check(bridge_code_q, 32'h4444_4444);
		$display("test rerun done");
	endtask

	// ****************************************************************
	// Verdict and main sequence
	// ****************************************************************
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		#100000;
		miscompares++;
		results();
	end

	initial begin
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		test_reset();
		test_static();
		test_codes();
		test_rerun();
		results();
	end
endmodule
